// file: rtl/strap_decode_pkg.sv
package strap_decode_pkg;
  // gain-select pin codes
  localparam logic [1:0] GAIN_CODE_LOW = 2'h0;
  localparam logic [1:0] GAIN_CODE_MID = 2'h1;
  localparam logic [1:0] GAIN_CODE_HIGH = 2'h2;
  localparam logic [1:0] GAIN_CODE_REG = 2'h3;
  // analog stage gain in tenths of a dBV
  localparam logic [7:0] ANA_GAIN_LOW = 8'hc0;
  localparam logic [7:0] ANA_GAIN_MID = 8'he2;
  localparam logic [7:0] ANA_GAIN_HIGH = 8'hfa;
  // digital path figures in tenths of a dB
  localparam logic [7:0] BOOST_HW = 8'h3c;
  localparam logic [7:0] VOLUME_HW = 8'h00;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  // control port lines rest high while the pins keep their strap meanings
  localparam logic CTL_LINE_IDLE = 1'h1;
  // output stage states, one-hot
  typedef enum logic [2:0] {
    STAGE_OFF = 3'h1,
    STAGE_SLEEP = 3'h2,
    STAGE_RUN = 3'h4
  } stage_type;
endpackage

// file: rtl/gain_code_decoder.sv
`timescale 1ns/1ps
module gain_code_decoder
  import strap_decode_pkg::*;
(
  input wire logic [1:0] gainCode,
  output logic regMode,
  output logic [7:0] anaGain
);
  always_comb begin
    regMode = 1'h0;
    case (gainCode)
      GAIN_CODE_LOW: anaGain = ANA_GAIN_LOW;
      GAIN_CODE_MID: anaGain = ANA_GAIN_MID;
      GAIN_CODE_HIGH: anaGain = ANA_GAIN_HIGH;
      default: begin
        anaGain = ANA_GAIN_HIGH;
        regMode = 1'h1;
      end
    endcase
  end
endmodule

// file: rtl/strap_mode_gain_decoder.sv
// Summary of operation
// - in hardware mode a high bridge-mode pin selects parallel bridge mode driving one speaker.
// - in hardware mode a low bridge-mode pin selects stereo bridge mode with two channels.
// - in parallel bridge mode the combined amplifier takes the right-channel sample, except in register mode with regRightChannelSel low, where it takes the left.
// - in hardware mode a high sleep pin moves the output stage to non-switching high impedance.
// - during sleep the signal-path blocks keep running for a fast resume.
// - gain code 11 leaves hardware mode and enters register control mode.
// - in hardware mode the digital volume stays fixed at unity gain.
// - in hardware mode the digital boost is a fixed +6 dB for every gain code.
// - gain code 00 selects 19.2 dBV and code 01 selects 22.6 dBV of analog gain.
// - a low shutdown pin enters shutdown and a high one leaves it.
// - in register mode the bridge and frequency pins become the control port clock and data.
`timescale 1ns/1ps
module strap_mode_gain_decoder
  import strap_decode_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 24
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bridgeModeClockPin,
  input wire logic switchFreqDataPin,
  input wire logic sleepAddressPin,
  input wire logic gainSelectHighPin,
  input wire logic gainSelectLowPin,
  input wire logic ampShutdownPin_n,
  input wire logic [SAMPLE_WIDTH-1:0] leftSample,
  input wire logic [SAMPLE_WIDTH-1:0] rightSample,
  input wire logic sampleValid,
  input wire logic regParallelMode,
  input wire logic regRightChannelSel,
  input wire logic [7:0] regAnaGain,
  input wire logic [7:0] regBoost,
  input wire logic [7:0] regVolume,
  output logic registerMode,
  output logic parallelBridgeMode,
  output logic controlClock,
  output logic controlData,
  output logic outputSwitching,
  output logic outputHighZ,
  output logic signalPathActive,
  output logic shutdown,
  output logic [7:0] analogStageGain,
  output logic [7:0] digitalBoost,
  output logic [7:0] digitalVolume,
  output logic [SAMPLE_WIDTH-1:0] ampSampleA,
  output logic [SAMPLE_WIDTH-1:0] ampSampleB,
  output logic ampSampleValid
);
  // ****************************************
  // stage decode
  // ****************************************
  // the stage flags travel as one registered word so every output pin is a plain flop bit
  typedef struct packed {
    logic switching;
    logic highZ;
    logic pathOn;
    logic off;
  } stage_pins_type;

  // one decode serves the reset value and the running value, so the pins never disagree with the stage
  function automatic stage_pins_type stage_pins(input stage_type s);
    stage_pins_type p;
    p.switching = (s == STAGE_RUN);
    p.highZ = (s != STAGE_RUN);
    p.pathOn = (s != STAGE_OFF);
    p.off = (s == STAGE_OFF);
    return p;
  endfunction

  logic hwRegMode;
  logic [7:0] hwAnaGain;
  logic regMode_q, regMode_d, parallel_q, parallel_d, ctlClk_q, ctlClk_d, ctlDat_q, ctlDat_d;
  logic [7:0] ana_q, ana_d, boost_q, boost_d, vol_q, vol_d;
  stage_type stage_q, stage_d;
  stage_pins_type pins_q, pins_d;
  logic [SAMPLE_WIDTH-1:0] sampA_q, sampA_d, sampB_q, sampB_d;
  logic sampV_q, sampV_d;

  gain_code_decoder u_gain (
    .gainCode({gainSelectHighPin, gainSelectLowPin}),
    .regMode(hwRegMode),
    .anaGain(hwAnaGain)
  );

  // ****************************************
  // mode and gain selection
  // ****************************************
  always_comb begin
    regMode_d = hwRegMode;
    if (hwRegMode) begin
      // register values replace every strap meaning
      parallel_d = regParallelMode;
      ana_d = regAnaGain;
      boost_d = regBoost;
      vol_d = regVolume;
    end else begin
      parallel_d = bridgeModeClockPin;
      ana_d = hwAnaGain;
      boost_d = BOOST_HW;
      vol_d = VOLUME_HW;
    end
  end

  // gains rest at zero through reset so nothing is amplified before the pins have been read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regMode_q <= 1'h0;
      parallel_q <= 1'h0;
      ana_q <= GAIN_RESET;
      boost_q <= GAIN_RESET;
      vol_q <= GAIN_RESET;
    end else begin
      regMode_q <= regMode_d;
      parallel_q <= parallel_d;
      ana_q <= ana_d;
      boost_q <= boost_d;
      vol_q <= vol_d;
    end
  end

  // ****************************************
  // control port lines
  // ****************************************
  // outside register mode the lines rest at the idle level of the control bus
  always_comb begin
    ctlClk_d = CTL_LINE_IDLE;
    ctlDat_d = CTL_LINE_IDLE;
    if (hwRegMode) begin
      ctlClk_d = bridgeModeClockPin;
      ctlDat_d = switchFreqDataPin;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctlClk_q <= CTL_LINE_IDLE;
      ctlDat_q <= CTL_LINE_IDLE;
    end else begin
      ctlClk_q <= ctlClk_d;
      ctlDat_q <= ctlDat_d;
    end
  end

  // ****************************************
  // output stage power state
  // ****************************************
  // shutdown outranks sleep; sleep is a strap meaning and so has no effect in register mode
  always_comb begin
    case (stage_q)
      STAGE_OFF, STAGE_SLEEP, STAGE_RUN: begin
        if (!ampShutdownPin_n) stage_d = STAGE_OFF;
        else if (sleepAddressPin && !hwRegMode) stage_d = STAGE_SLEEP;
        else stage_d = STAGE_RUN;
      end
      default: stage_d = STAGE_OFF;
    endcase
    pins_d = stage_pins(stage_d);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_q <= STAGE_OFF;
      pins_q <= stage_pins(STAGE_OFF);
    end else begin
      stage_q <= stage_d;
      pins_q <= pins_d;
    end
  end

  // ****************************************
  // sample routing to the two amplifier halves
  // ****************************************
  // routing follows the registered mode, one cycle behind the pins, so a mode change never splits a pair
  always_comb begin
    sampV_d = sampleValid && pins_q.pathOn;
    sampA_d = sampA_q;
    sampB_d = sampB_q;
    if (sampleValid) begin
      if (parallel_q) begin
        // a source that inverts its frame clock puts its wanted channel in this slot
        sampA_d = (regMode_q && !regRightChannelSel) ? leftSample : rightSample;
        sampB_d = sampA_d;
      end else begin
        sampA_d = leftSample;
        sampB_d = rightSample;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sampA_q <= '0;
      sampB_q <= '0;
      sampV_q <= 1'h0;
    end else begin
      sampA_q <= sampA_d;
      sampB_q <= sampB_d;
      sampV_q <= sampV_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a flop; sleep keeps the signal path alive and only shutdown stops it
  assign registerMode = regMode_q;
  assign parallelBridgeMode = parallel_q;
  assign controlClock = ctlClk_q;
  assign controlData = ctlDat_q;
  assign outputSwitching = pins_q.switching;
  assign outputHighZ = pins_q.highZ;
  assign signalPathActive = pins_q.pathOn;
  assign shutdown = pins_q.off;
  assign analogStageGain = ana_q;
  assign digitalBoost = boost_q;
  assign digitalVolume = vol_q;
  assign ampSampleA = sampA_q;
  assign ampSampleB = sampB_q;
  assign ampSampleValid = sampV_q;
endmodule

// file: dv/strap_decoder_properties.sv
`timescale 1ns/1ps
module strap_decoder_checker
  import strap_decode_pkg::*;
(
  input wire logic sys_clk, rst, bridgeModeClockPin, sleepAddressPin, gainSelectHighPin, gainSelectLowPin,
  input wire logic ampShutdownPin_n, registerMode, parallelBridgeMode, outputHighZ, shutdown,
  input wire logic switchFreqDataPin, controlClock, controlData, outputSwitching, signalPathActive,
  input wire logic [7:0] analogStageGain, digitalBoost, digitalVolume, regAnaGain, regBoost, regVolume
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic up_q, hw;
  always_ff @(posedge sys_clk) up_q <= !rst;
  assign hw = up_q && !registerMode;
  property p_reg; up_q |-> registerMode == $past(gainSelectHighPin && gainSelectLowPin); endproperty
  a_reg: assert property (p_reg) else $error("mode");
  property p_pbm; hw |-> parallelBridgeMode == $past(bridgeModeClockPin); endproperty
  a_pbm: assert property (p_pbm) else $error("bridge");
  property p_vol; hw |-> digitalVolume == VOLUME_HW; endproperty
  a_vol: assert property (p_vol) else $error("volume");
  property p_bst; hw |-> digitalBoost == BOOST_HW; endproperty
  a_bst: assert property (p_bst) else $error("boost");
  property p_ana; hw |-> analogStageGain == ($past(gainSelectHighPin) ? ANA_GAIN_HIGH
    : $past(gainSelectLowPin) ? ANA_GAIN_MID : ANA_GAIN_LOW); endproperty
  a_ana: assert property (p_ana) else $error("gain");
  property p_slp; hw && !shutdown |-> outputHighZ == $past(sleepAddressPin); endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_off; up_q |-> shutdown == !$past(ampShutdownPin_n); endproperty
  a_off: assert property (p_off) else $error("shutdown");
  property p_hiz; shutdown |-> outputHighZ; endproperty
  a_hiz: assert property (p_hiz) else $error("stage");
  property p_ckl; up_q |-> controlClock == (registerMode ? $past(bridgeModeClockPin) : CTL_LINE_IDLE); endproperty
  a_ckl: assert property (p_ckl) else $error("control clock");
  property p_dat; up_q |-> controlData == (registerMode ? $past(switchFreqDataPin) : CTL_LINE_IDLE); endproperty
  a_dat: assert property (p_dat) else $error("control data");
  property p_rgv; up_q && registerMode |-> analogStageGain == $past(regAnaGain) && digitalBoost == $past(regBoost)
    && digitalVolume == $past(regVolume); endproperty
  a_rgv: assert property (p_rgv) else $error("register gains");
  property p_rsl; up_q && registerMode && !shutdown |-> outputSwitching; endproperty
  a_rsl: assert property (p_rsl) else $error("register sleep");
  property p_pth; up_q |-> signalPathActive == $past(ampShutdownPin_n); endproperty
  a_pth: assert property (p_pth) else $error("signal path");
  property p_run; hw && !shutdown |-> outputSwitching == !$past(sleepAddressPin); endproperty
  a_run: assert property (p_run) else $error("switching");
  property p_swz; up_q |-> outputSwitching != outputHighZ; endproperty
  a_swz: assert property (p_swz) else $error("stage pins");
endmodule
bind strap_mode_gain_decoder strap_decoder_checker chk (.*);

// file: dv/strap_board.sv
`timescale 1ns/1ps
module strap_board (
  input wire logic [4:0] strapSel,
  output logic bridgeModeClockPin, gainSelectHighPin, gainSelectLowPin, ampShutdownPin_n, sleepAddressPin
);
  assign {bridgeModeClockPin, gainSelectHighPin, gainSelectLowPin, ampShutdownPin_n} = strapSel[3:0];
  // sleep goes up with shutdown so the stage stops quietly
  assign sleepAddressPin = strapSel[4] | !strapSel[0];
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'h0, rst = 1'h1, sampleValid = 1'h0, regParallelMode, regRightChannelSel, switchFreqDataPin;
  logic bridgeModeClockPin, sleepAddressPin, gainSelectHighPin, gainSelectLowPin, ampShutdownPin_n, shutdown;
  logic registerMode, parallelBridgeMode, controlClock, controlData, outputSwitching, outputHighZ, signalPathActive;
  logic ampSampleValid;
  logic [4:0] strapSel;
  logic [7:0] regAnaGain, regBoost, regVolume, analogStageGain, digitalBoost, digitalVolume;
  logic [23:0] leftSample, rightSample, ampSampleA, ampSampleB, src;
  logic [47:0] expQ[$];
  int fails = 0, cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  strap_board board (.*);
  strap_mode_gain_decoder DUT (.*);
  task shuffle;
    {strapSel, regParallelMode, regRightChannelSel, switchFreqDataPin, regAnaGain, regBoost, regVolume} = $urandom;
    {leftSample, rightSample} = 48'({$urandom, $urandom});
    // a source that inverted its frame clock hands over its channels swapped
    if (regVolume[0]) {leftSample, rightSample} = {rightSample, leftSample};
  endtask
  task step;
    @(negedge sys_clk) shuffle();
    @(negedge sys_clk) sampleValid = 1'h1;
    src = &strapSel[2:1] && !regRightChannelSel ? leftSample : rightSample;
    if (strapSel[0]) expQ.push_back((&strapSel[2:1] ? regParallelMode : strapSel[3])
      ? {src, src} : {leftSample, rightSample});
    @(negedge sys_clk) sampleValid = 1'h0;
  endtask
  task cmp_ab(input logic [47:0] e);
    cmp_count++;
    if (e !== {ampSampleA, ampSampleB}) begin
      fails++;
      $display("Error ampSample exp %h got %h", e, {ampSampleA, ampSampleB});
    end
  endtask
  always @(posedge sys_clk) #1 if (ampSampleValid === 1'h1) cmp_ab(expQ.size() ? expQ.pop_front() : 'x);
  task test_done;
    fails += expQ.size();
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial #20000 begin
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(20));
    shuffle();
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'h0;
    repeat (300) step();
    repeat (2) @(negedge sys_clk);
    test_done();
  end
endmodule
